//--- htq_cfg.svh
/*
  Constants for the transmit descriptor sequencer: register offsets, descriptor field
  positions, done status codes and reset values.
  Assumes it is included by bare name from the design module.
*/
`ifndef HTQ_CFG_SVH
`define HTQ_CFG_SVH

`define HTQ_OFS_BASE   8'h00
`define HTQ_OFS_CSEL   8'h04
`define HTQ_OFS_CDATA  8'h08
`define HTQ_OFS_STAT   8'h0c

`define HTQ_RST_BASE   32'h0000_0000
`define HTQ_RST_CSEL   8'h00
`define HTQ_RST_CHANNEL_ACTIVE_BIT   1'h0
`define HTQ_RST_DQS    1'h0
`define HTQ_RST_SDI    16'h0000

`define HTQ_EOP_BIT    31
`define HTQ_CHV_BIT    30
`define HTQ_BC_MSB     28
`define HTQ_BC_LSB     16
`define HTQ_PLV_BIT    16
`define HTQ_LRST_BIT   17
`define HTQ_LCH_LSB    18
`define HTQ_LCH_MSB    25

`define HTQ_W_ADDR     2'h0
`define HTQ_W_CTRL     2'h1
`define HTQ_W_CHAN     2'h2
`define HTQ_W_LINK     2'h3

`define HTQ_ST_PKT     3'h0
`define HTQ_ST_FIRST   3'h1
`define HTQ_ST_MID     3'h2
`define HTQ_ST_LAST    3'h3
`define HTQ_ST_OFF     3'h4
`define HTQ_ST_DESC    3'h5
`define HTQ_ST_ABORT   3'h6
`define HTQ_ST_UFLOW   3'h7

`endif

//--- htq_pkg.sv
/*
  Types shared by the transmit descriptor sequencer and its surroundings.
  Assumes htq_cfg.svh is on the include path.
*/
package htq_pkg;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_PICK  = 4'h1,
    S_RD1   = 4'h3,
    S_RD2   = 4'h2,
    S_RD0   = 4'h6,
    S_CHECK = 4'h7,
    S_XFER  = 4'h5,
    S_DONEQ = 4'h4,
    S_ADV   = 4'hc,
    S_RD3   = 4'hd,
    S_LINK  = 4'h8
  } htq_state_t;

  typedef struct packed {
    logic        rst;
    logic        urg;
    logic [7:0]  ch;
    logic [15:0] ptr;
  } htq_pq_t;

  typedef struct packed {
    logic [2:0]  st;
    logic [7:0]  ch;
    logic [15:0] desc;
  } htq_dq_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [12:0] cnt;
    logic [7:0]  ch;
  } htq_xfer_t;

  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } htq_mem_t;

endpackage

//--- htq_tx_dma.sv
/*
  Transmit descriptor sequencer: walks buffer and packet chains, links extra chains
  in memory, gives urgent chains precedence, reports to the done queue, handles errors.
  Assumes a classic Wishbone master, a memory port that answers every request with
  mem_ack_i, a buffer mover started by xfer_start_o, and a done queue sink.
  // Function
  // (RL1) Host clears end flag except last buffer
  // (RL2) Unended descriptor: fetch next buffer by index
  // (RL3) Chain flag only read on packet end
  // (RL4) End plus chain flag: next packet follows
  // (RL5) Two chains inside, further ones linked outside
  // (RL6) Link writes index and valid into head
  // (RL7) Urgent entries go ahead of standard ones
  // (RL8) Urgent starts after current standard packet
  // (RL9) All urgent first, then resume standard chain
  // (RL10) Urgent packets sent in arrival order
  // (RL11) One start index per channel, both queues
  // (RL12) Report select: per packet or per buffer
  // (RL13) Per packet success reports status 000
  // (RL14) Per buffer: first 001, middle 010, last 011
  // (RL15) Errors clear channel and report descriptor
  // (RL16) Disabled 100, descriptor fault 101
  // (RL17) Bus abort 110, underflow 111
  // (RL18) Disabled channel descriptors returned with 100
  // (RL19) Host waits, re-enables, re-queues
  // (RL20) Restart flag re-enables after earlier returns
  // (RL21) Host clears link fields before re-queue
  // (RL22) Next field is index from base
  // (RL23) Word 1: bit 31 end, bit 30 chain
  // (RL24) Check errors before moving any data
*/
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "htq_cfg.svh"

module htq_tx_dma #(
  parameter int NCH = 256
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic                   wb_ack_o,
  output logic [31:0]            wb_dat_o,
  input  wire logic              pq_valid_i,
  input  wire htq_pkg::htq_pq_t  pq_i,
  output logic                   pq_ready_o,
  output logic                   mem_req_o,
  output htq_pkg::htq_mem_t      mem_o,
  input  wire logic              mem_ack_i,
  input  wire logic              mem_abort_i,
  input  wire logic [31:0]       mem_rdata_i,
  output logic                   xfer_start_o,
  output htq_pkg::htq_xfer_t     xfer_o,
  input  wire logic              xfer_done_i,
  input  wire logic              xfer_underflow_i,
  input  wire logic              xfer_abort_i,
  output logic                   dq_valid_o,
  output htq_pkg::htq_dq_t       dq_o,
  input  wire logic              dq_ready_i
);

  function automatic logic [31:0] daddr(input logic [31:0] b, input logic [15:0] i,
                                        input logic [1:0] w);
    daddr = b + {12'h000, i, w, 2'b00};
  endfunction

  htq_pkg::htq_state_t st_q;
  htq_pkg::htq_pq_t    ent_q;
  htq_pkg::htq_mem_t   mem_q;
  htq_pkg::htq_xfer_t  xfer_q;
  htq_pkg::htq_dq_t    dq_q;
  logic                ent_v_q;
  logic                ent_used;
  logic                pq_take;
  logic                pq_ready_q;
  logic                wb_ack_q;
  logic [31:0]         wb_dat_q;
  logic [31:0]         base_q;
  logic [7:0]          csel_q;
  logic                channel_active_bit_q [NCH];
  logic                dqs_q  [NCH];
  logic [15:0]         sdi_q  [NCH];
  logic                channel_active_bit_clr_q;
  logic                channel_active_bit_set_q;
  logic                sdi_wr_q;
  logic [7:0]          cfg_ch_q;
  logic [15:0]         sdi_val_q;
  logic [1:0]          busy_q;
  logic [15:0]         first_q [2];
  logic [15:0]         cur_q   [2];
  logic [15:0]         tail_q  [2];
  logic [7:0]          ch_q    [2];
  logic [1:0]          rsf_q;
  logic                cls_q;
  logic                in_pkt_q;
  logic                fst_q;
  logic                abrt_q;
  logic [15:0]         pkt_first_q;
  logic [31:0]         d1_q;
  logic [7:0]          d2_q;
  logic                mem_req_q;
  logic                xfer_start_q;
  logic                dq_v_q;
  logic [2:0]          last_st_q;
  logic                nc;
  logic [7:0]          chan;
  logic                eop;
  logic                chv;
  logic                wb_hit;
  logic                wb_wr;

  assign nc       = in_pkt_q ? cls_q : busy_q[1];
  assign chan     = ch_q[cls_q];
  assign eop      = d1_q[`HTQ_EOP_BIT];          // [RL23]
  assign chv      = d1_q[`HTQ_CHV_BIT];          // [RL23]
  assign wb_hit   = wb_cyc_i && wb_stb_i && !wb_ack_q;
  assign wb_wr    = wb_hit && wb_we_i;
  assign pq_take  = pq_valid_i && pq_ready_q;
  assign ent_used = ent_v_q && (st_q == htq_pkg::S_IDLE);

  assign wb_ack_o     = wb_ack_q;
  assign wb_dat_o     = wb_dat_q;
  assign pq_ready_o   = pq_ready_q;
  assign mem_req_o    = mem_req_q;
  assign mem_o        = mem_q;
  assign xfer_start_o = xfer_start_q;
  assign xfer_o       = xfer_q;
  assign dq_valid_o   = dq_v_q;
  assign dq_o         = dq_q;

  // Bus slave: one wait state, unmapped reads return zero and writes are dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= wb_hit;
      wb_dat_q <= 32'h0000_0000;
      if (wb_hit && !wb_we_i) begin
        if (wb_adr_i == `HTQ_OFS_BASE) begin
          wb_dat_q <= base_q;
        end else if (wb_adr_i == `HTQ_OFS_CSEL) begin
          wb_dat_q <= {24'h000000, csel_q};
        end else if (wb_adr_i == `HTQ_OFS_CDATA) begin
          wb_dat_q <= {sdi_q[csel_q], 14'h0000, dqs_q[csel_q], channel_active_bit_q[csel_q]};
        end else if (wb_adr_i == `HTQ_OFS_STAT) begin
          wb_dat_q <= {21'h000000, last_st_q, busy_q, cls_q, in_pkt_q, st_q};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_q <= `HTQ_RST_BASE;
      csel_q <= `HTQ_RST_CSEL;
    end else if (wb_wr) begin
      if (wb_adr_i == `HTQ_OFS_BASE) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            base_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end else if (wb_adr_i == `HTQ_OFS_CSEL && wb_sel_i[0]) begin
        csel_q <= wb_dat_i[7:0];
      end
    end
  end

  // Channel table: hardware clear and restart take precedence over software writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCH; i++) begin
        channel_active_bit_q[i] <= `HTQ_RST_CHANNEL_ACTIVE_BIT;
        dqs_q[i]  <= `HTQ_RST_DQS;
        sdi_q[i]  <= `HTQ_RST_SDI;
      end
    end else begin
      if (wb_wr && wb_adr_i == `HTQ_OFS_CDATA && wb_sel_i[0]) begin
        channel_active_bit_q[csel_q] <= wb_dat_i[0];
        dqs_q[csel_q]  <= wb_dat_i[1];
      end
      if (channel_active_bit_clr_q) begin
        channel_active_bit_q[cfg_ch_q] <= 1'b0;                // [RL15]
      end
      if (channel_active_bit_set_q) begin
        channel_active_bit_q[cfg_ch_q] <= 1'b1;                // [RL20]
      end
      if (sdi_wr_q) begin
        sdi_q[cfg_ch_q] <= sdi_val_q;            // [RL11]
      end
    end
  end

  // One pending entry is held; the port stalls until the sequencer has used it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ent_v_q    <= 1'b0;
      ent_q      <= '0;
      pq_ready_q <= 1'b0;
    end else begin
      if (pq_take) begin
        ent_v_q <= 1'b1;
        ent_q   <= pq_i;
      end else if (ent_used) begin
        ent_v_q <= 1'b0;
      end
      pq_ready_q <= !pq_take && !(ent_v_q && !ent_used);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q         <= htq_pkg::S_IDLE;
      busy_q       <= 2'b00;
      rsf_q        <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        first_q[c] <= 16'h0000;
        cur_q[c]   <= 16'h0000;
        tail_q[c]  <= 16'h0000;
        ch_q[c]    <= 8'h00;
      end
      cls_q        <= 1'b0;
      in_pkt_q     <= 1'b0;
      fst_q        <= 1'b1;
      abrt_q       <= 1'b0;
      pkt_first_q  <= 16'h0000;
      d1_q         <= 32'h0000_0000;
      d2_q         <= 8'h00;
      mem_req_q    <= 1'b0;
      mem_q        <= '0;
      xfer_start_q <= 1'b0;
      xfer_q       <= '0;
      dq_v_q       <= 1'b0;
      dq_q         <= '0;
      last_st_q    <= `HTQ_ST_PKT;
      channel_active_bit_clr_q   <= 1'b0;
      channel_active_bit_set_q   <= 1'b0;
      sdi_wr_q     <= 1'b0;
      cfg_ch_q     <= 8'h00;
      sdi_val_q    <= 16'h0000;
    end else begin
      xfer_start_q <= 1'b0;
      channel_active_bit_clr_q   <= 1'b0;
      channel_active_bit_set_q   <= 1'b0;
      sdi_wr_q     <= 1'b0;
      case (st_q)
        htq_pkg::S_IDLE: begin
          if (ent_v_q) begin
            if (busy_q[ent_q.urg]) begin
              // Channel number and restart flag ride in the spare bits of the link word.
              mem_req_q <= 1'b1;                                       // [RL5]
              mem_q     <= '{we: 1'b1, addr: daddr(base_q, tail_q[ent_q.urg], `HTQ_W_LINK),
                             wdata: {6'h00, ent_q.ch, ent_q.rst, 1'b1, ent_q.ptr}}; // [RL6]
              tail_q[ent_q.urg] <= ent_q.ptr;                          // [RL10]
              st_q      <= htq_pkg::S_LINK;
            end else begin
              busy_q[ent_q.urg]  <= 1'b1;                              // [RL5]
              first_q[ent_q.urg] <= ent_q.ptr;
              cur_q[ent_q.urg]   <= ent_q.ptr;
              tail_q[ent_q.urg]  <= ent_q.ptr;
              ch_q[ent_q.urg]    <= ent_q.ch;
              rsf_q[ent_q.urg]   <= ent_q.rst;
            end
          end else if (busy_q != 2'b00) begin
            st_q <= htq_pkg::S_PICK;
          end
        end
        htq_pkg::S_PICK: begin
          cls_q <= nc;                                                 // [RL7] [RL8] [RL9]
          if (rsf_q[nc]) begin
            rsf_q[nc]  <= 1'b0;
            channel_active_bit_set_q <= 1'b1;                                        // [RL20]
          end
          if (cur_q[nc] == first_q[nc]) begin
            sdi_wr_q  <= 1'b1;                                         // [RL11]
            sdi_val_q <= first_q[nc];
          end
          cfg_ch_q  <= ch_q[nc];
          if (fst_q) begin
            pkt_first_q <= cur_q[nc];
          end
          mem_req_q <= 1'b1;
          mem_q     <= '{we: 1'b0, addr: daddr(base_q, cur_q[nc], `HTQ_W_CTRL),
                         wdata: 32'h0000_0000};                        // [RL22]
          st_q      <= htq_pkg::S_RD1;
        end
        htq_pkg::S_RD1, htq_pkg::S_RD2, htq_pkg::S_RD0: begin
          if (mem_ack_i) begin
            mem_req_q <= 1'b0;
            if (mem_abort_i) begin
              abrt_q     <= 1'b1;
              channel_active_bit_clr_q <= 1'b1;                                      // [RL15]
              dq_v_q     <= 1'b1;
              dq_q       <= '{st: `HTQ_ST_ABORT, ch: chan, desc: cur_q[cls_q]}; // [RL17]
              st_q       <= htq_pkg::S_DONEQ;
            end else if (st_q == htq_pkg::S_RD1) begin
              d1_q      <= mem_rdata_i;
              mem_req_q <= 1'b1;
              mem_q.addr <= daddr(base_q, cur_q[cls_q], `HTQ_W_CHAN);
              st_q      <= htq_pkg::S_RD2;
            end else if (st_q == htq_pkg::S_RD2) begin
              d2_q      <= mem_rdata_i[7:0];
              mem_req_q <= 1'b1;
              mem_q.addr <= daddr(base_q, cur_q[cls_q], `HTQ_W_ADDR);
              st_q      <= htq_pkg::S_RD0;
            end else begin
              xfer_q <= '{addr: mem_rdata_i, cnt: d1_q[`HTQ_BC_MSB:`HTQ_BC_LSB], ch: chan};
              st_q   <= htq_pkg::S_CHECK;
            end
          end
        end
        htq_pkg::S_CHECK: begin
          // Faults are judged before any data moves.
          if (!channel_active_bit_q[chan]) begin
            dq_v_q <= 1'b1;
            dq_q   <= '{st: `HTQ_ST_OFF, ch: chan, desc: cur_q[cls_q]};  // [RL16] [RL18]
            st_q   <= htq_pkg::S_DONEQ;
          end else if (xfer_q.cnt == 13'h0000 || d2_q != chan) begin     // [RL24]
            channel_active_bit_clr_q <= 1'b1;                                          // [RL15]
            dq_v_q     <= 1'b1;
            dq_q       <= '{st: `HTQ_ST_DESC, ch: chan, desc: cur_q[cls_q]}; // [RL16]
            st_q       <= htq_pkg::S_DONEQ;
          end else begin
            xfer_start_q <= 1'b1;
            st_q         <= htq_pkg::S_XFER;
          end
        end
        htq_pkg::S_XFER: begin
          if (xfer_abort_i) begin
            channel_active_bit_clr_q <= 1'b1;                                          // [RL15]
            dq_v_q     <= 1'b1;
            dq_q       <= '{st: `HTQ_ST_ABORT, ch: chan, desc: cur_q[cls_q]}; // [RL17]
            st_q       <= htq_pkg::S_DONEQ;
          end else if (xfer_underflow_i) begin
            channel_active_bit_clr_q <= 1'b1;                                          // [RL15]
            dq_v_q     <= 1'b1;
            dq_q       <= '{st: `HTQ_ST_UFLOW, ch: chan, desc: cur_q[cls_q]}; // [RL17]
            st_q       <= htq_pkg::S_DONEQ;
          end else if (xfer_done_i) begin
            if (dqs_q[chan]) begin                                       // [RL12]
              dq_v_q <= 1'b1;
              dq_q   <= '{st: eop ? `HTQ_ST_LAST : (fst_q ? `HTQ_ST_FIRST : `HTQ_ST_MID),
                          ch: chan, desc: cur_q[cls_q]};                 // [RL14]
              st_q   <= htq_pkg::S_DONEQ;
            end else if (eop) begin
              dq_v_q <= 1'b1;
              dq_q   <= '{st: `HTQ_ST_PKT, ch: chan, desc: pkt_first_q}; // [RL13]
              st_q   <= htq_pkg::S_DONEQ;
            end else begin
              st_q <= htq_pkg::S_ADV;
            end
          end
        end
        htq_pkg::S_DONEQ: begin
          if (dq_ready_i) begin
            dq_v_q    <= 1'b0;
            last_st_q <= dq_q.st;
            st_q      <= htq_pkg::S_ADV;
          end
        end
        htq_pkg::S_ADV: begin
          if (abrt_q) begin
            // The chain cannot be followed once a descriptor read was aborted.
            abrt_q        <= 1'b0;
            busy_q[cls_q] <= 1'b0;
            in_pkt_q      <= 1'b0;
            fst_q         <= 1'b1;
            st_q          <= htq_pkg::S_IDLE;
          end else if (!eop) begin
            cur_q[cls_q] <= d1_q[15:0];                                  // [RL2] [RL3]
            in_pkt_q     <= 1'b1;
            fst_q        <= 1'b0;
            st_q         <= htq_pkg::S_IDLE;
          end else if (chv) begin
            cur_q[cls_q] <= d1_q[15:0];                                  // [RL4]
            in_pkt_q     <= 1'b0;
            fst_q        <= 1'b1;
            st_q         <= htq_pkg::S_IDLE;
          end else begin
            in_pkt_q  <= 1'b0;
            fst_q     <= 1'b1;
            mem_req_q <= 1'b1;
            mem_q     <= '{we: 1'b0, addr: daddr(base_q, first_q[cls_q], `HTQ_W_LINK),
                           wdata: 32'h0000_0000};
            st_q      <= htq_pkg::S_RD3;
          end
        end
        htq_pkg::S_RD3: begin
          if (mem_ack_i) begin
            mem_req_q <= 1'b0;
            if (!mem_abort_i && mem_rdata_i[`HTQ_PLV_BIT]) begin
              first_q[cls_q] <= mem_rdata_i[15:0];                       // [RL5]
              cur_q[cls_q]   <= mem_rdata_i[15:0];
              ch_q[cls_q]    <= mem_rdata_i[`HTQ_LCH_MSB:`HTQ_LCH_LSB];
              rsf_q[cls_q]   <= mem_rdata_i[`HTQ_LRST_BIT];
            end else begin
              busy_q[cls_q] <= 1'b0;
            end
            st_q <= htq_pkg::S_IDLE;
          end
        end
        htq_pkg::S_LINK: begin
          if (mem_ack_i) begin
            mem_req_q <= 1'b0;
            st_q      <= htq_pkg::S_IDLE;
          end
        end
        default: begin
          st_q <= htq_pkg::S_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence chk_off_s;
    st_q == htq_pkg::S_CHECK && !channel_active_bit_q[chan];
  endsequence

  sequence dq_off_s;
    dq_v_q && dq_q.st == `HTQ_ST_OFF && !xfer_start_q;
  endsequence

  off_status_a: assert property (chk_off_s |=> dq_off_s) // [RL18]
    else $error("disabled channel not reported with status 100");

  zero_count_a: assert property (st_q == htq_pkg::S_CHECK && xfer_q.cnt == 13'h0000 |=> // [RL24]
    !xfer_start_q && dq_q.st != `HTQ_ST_PKT)
    else $error("zero byte count descriptor was started");

  desc_fault_a: assert property (st_q == htq_pkg::S_CHECK && channel_active_bit_q[chan] && d2_q != chan // [RL16]
    |=> dq_v_q && dq_q.st == `HTQ_ST_DESC ##1 !channel_active_bit_q[cfg_ch_q])
    else $error("channel mismatch not reported or channel left enabled");

  uflow_clear_a: assert property (st_q == htq_pkg::S_XFER && !xfer_abort_i && xfer_underflow_i // [RL17]
    |=> dq_q.st == `HTQ_ST_UFLOW ##1 !channel_active_bit_q[cfg_ch_q])
    else $error("underflow not reported with 111 or channel not cleared");

  link_word_a: assert property (st_q == htq_pkg::S_LINK && mem_req_q |-> mem_q.we && // [RL6]
    mem_q.wdata[`HTQ_PLV_BIT] && mem_q.addr[3:2] == `HTQ_W_LINK)
    else $error("external link write malformed");

  urgent_first_a: assert property (st_q == htq_pkg::S_PICK && !in_pkt_q && busy_q[1] // [RL7]
    |=> cls_q && st_q == htq_pkg::S_RD1)
    else $error("standard chain chosen while urgent chain queued");

  mid_packet_a: assert property (st_q == htq_pkg::S_PICK && in_pkt_q |=> // [RL8]
    cls_q == $past(cls_q))
    else $error("class switched inside a packet");

  next_buf_a: assert property (st_q == htq_pkg::S_ADV && !abrt_q && !eop |=> // [RL2]
    cur_q[cls_q] == $past(d1_q[15:0]) && in_pkt_q)
    else $error("next buffer of packet not followed");

  ctrl_addr_a: assert property (st_q == htq_pkg::S_RD1 && mem_req_q |-> // [RL22]
    mem_q.addr == daddr(base_q, cur_q[cls_q], `HTQ_W_CTRL))
    else $error("descriptor word 1 address not base plus index");

  pkt_status_a: assert property (st_q == htq_pkg::S_XFER && xfer_done_i && !xfer_abort_i && // [RL13]
    !xfer_underflow_i && eop && !dqs_q[chan] |=> dq_v_q && dq_q.st == `HTQ_ST_PKT)
    else $error("per packet success not reported as 000");

endmodule

//--- htq_host_model.sv
/* Host memory and buffer mover model facing the transmit sequencer.
   Assumes one memory request at a time and a descriptor base of zero. */
`timescale 1ns/10ps
module htq_host_model (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              mem_req_i,
  input  wire htq_pkg::htq_mem_t mem_i,
  output logic                   mem_ack_o,
  output logic [31:0]            mem_rdata_o,
  input  wire logic              xfer_start_i,
  input  wire logic              uflow_i,
  output logic                   xfer_done_o,
  output logic                   xfer_uflow_o
);
  logic [31:0] mem [64];
  logic [1:0]  cnt_q;
  wire  [5:0]  wi = mem_i.addr[7:2];
  always @(posedge clk_i) begin
    mem_ack_o <= !rst_i & mem_req_i & !mem_ack_o;
    // Read data flips when not answering, so a stale word never looks valid.
    mem_rdata_o <= (mem_req_i & !mem_ack_o) ? mem[wi] : ~mem_rdata_o;
    if (mem_req_i & !mem_ack_o & mem_i.we) begin
      mem[wi] <= mem_i.wdata;
    end
  end
  always_ff @(posedge clk_i) begin
    cnt_q        <= rst_i ? 2'h0 : xfer_start_i ? 2'h3 : (cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0;
    xfer_done_o  <= !rst_i & (cnt_q == 2'h1) & !uflow_i;
    xfer_uflow_o <= !rst_i & (cnt_q == 2'h1) & uflow_i;
  end
endmodule

//--- test_hdlc_tx_dma_queue_control.sv
/* Register and queue level bench for the transmit sequencer.
   Assumes the host model answers memory and buffer moves. */
`timescale 1ns/10ps
module test_hdlc_tx_dma_queue_control;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0;
  logic              we = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       wd = 32'h0;
  logic [31:0]       rd;
  logic              ack;
  logic              pq_valid = 1'b0;
  logic              pq_ready;
  logic              uflow = 1'b0;
  logic              urgent = 1'b0;
  logic              ma = 1'b0;
  logic              xa = 1'b0;
  htq_pkg::htq_xfer_t xo;
  htq_pkg::htq_pq_t  pq = '0;
  logic              mreq, mack, xs, xd, xu, dqv;
  htq_pkg::htq_mem_t mo;
  logic [31:0]       mrd;
  htq_pkg::htq_dq_t  dq;
  int                fail_count = 0;
  int                cmp_count = 0;
  always #5 clk_i = ~clk_i;
  htq_tx_dma dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_ack_o(ack), .wb_dat_o(rd),
    .pq_valid_i(pq_valid), .pq_i(pq), .pq_ready_o(pq_ready), .mem_req_o(mreq), .mem_o(mo),
    .mem_ack_i(mack), .mem_abort_i(ma), .mem_rdata_i(mrd), .xfer_start_o(xs), .xfer_o(xo),
    .xfer_done_i(xd), .xfer_underflow_i(xu), .xfer_abort_i(xa), .dq_valid_o(dqv),
    .dq_o(dq), .dq_ready_i(1'b1));
  htq_host_model host (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mreq), .mem_i(mo),
    .mem_ack_o(mack), .mem_rdata_o(mrd), .xfer_start_i(xs), .uflow_i(uflow),
    .xfer_done_o(xd), .xfer_uflow_o(xu));
  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(inout int n);
    n++;
    if (n > 3000) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge clk_i);
      tick(n);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cfg(input logic [7:0] ch, input logic dqs);
    logic [31:0] q;
    wb(1'b1, 8'h04, {24'h0, ch}, q);
    wb(1'b1, 8'h08, {30'h0, dqs, 1'b1}, q);
  endtask
  task automatic pend(input logic [7:0] ch, input logic [15:0] p, input logic r);
    int n = 0;
    pq_valid <= 1'b1;
    pq       <= '{rst: r, urg: urgent, ch: ch, ptr: p};
    do begin
      @(posedge clk_i);
      tick(n);
    end while (pq_ready !== 1'b1);
    pq_valid <= 1'b0;
  endtask
  task automatic exp_dq(input logic [2:0] st, input logic [15:0] d);
    int n = 0;
    do begin
      @(negedge clk_i);
      tick(n);
    end while (dqv !== 1'b1);
    cmp("done status", {29'h0, st}, {29'h0, dq.st});
    cmp("done descriptor", {16'h0, d}, {16'h0, dq.desc});
    @(posedge clk_i);
  endtask
  task automatic desc(input int i, input logic e, input logic c, input logic [12:0] n,
                      input logic [15:0] nx, input logic [7:0] ch);
    host.mem[i*4]   = 32'h1000_0000 + i;
    host.mem[i*4+1] = {e, c, 1'b0, n, nx};
    host.mem[i*4+2] = {24'h0, ch};
    host.mem[i*4+3] = 32'h0;
  endtask
  initial begin
    logic [31:0] q;
    desc(0, 1'b0, 1'b0, 13'h0040, 16'h0002, 8'h03);
    desc(1, 1'b0, 1'b0, 13'h0040, 16'h0000, 8'h03);
    desc(2, 1'b1, 1'b1, 13'h1fff, 16'h0003, 8'h03);
    desc(3, 1'b1, 1'b0, 13'h0001, 16'h0000, 8'h03);
    desc(4, 1'b0, 1'b1, 13'h0010, 16'h0005, 8'h05);
    desc(5, 1'b1, 1'b0, 13'h0010, 16'h0000, 8'h05);
    desc(6, 1'b1, 1'b0, 13'h0000, 16'h0000, 8'h05);
    desc(7, 1'b1, 1'b0, 13'h0020, 16'h0000, 8'h05);
    desc(8, 1'b1, 1'b0, 13'h0020, 16'h0000, 8'h09);
    desc(9, 1'b1, 1'b0, 13'h0020, 16'h0000, 8'h09);
    desc(10, 1'b1, 1'b0, 13'h0020, 16'h0000, 8'h05);
    desc(11, 1'b1, 1'b1, 13'h0020, 16'h000c, 8'h05);
    desc(12, 1'b1, 1'b0, 13'h0020, 16'h0000, 8'h05);
    desc(13, 1'b1, 1'b1, 13'h0020, 16'h000f, 8'h05);
    desc(14, 1'b1, 1'b0, 13'h0020, 16'h0000, 8'h05);
    desc(15, 1'b1, 1'b0, 13'h0020, 16'h0000, 8'h05);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0, q);
    cmp("unmapped read", 32'h0, q);
    wb(1'b1, 8'h00, 32'h0, q);
    cfg(8'h03, 1'b1);
    cfg(8'h05, 1'b0);
    cfg(8'h09, 1'b0);
    pend(8'h03, 16'h0001, 1'b0);
    exp_dq(3'h1, 16'h0001);
    exp_dq(3'h2, 16'h0000);
    exp_dq(3'h3, 16'h0002);
    exp_dq(3'h3, 16'h0003);
    cmp("buffer address", 32'h1000_0003, xo.addr);
    cmp("byte count", 32'h0000_0001, {19'h0, xo.cnt});
    pend(8'h05, 16'h0004, 1'b0);
    exp_dq(3'h0, 16'h0004);
    pend(8'h05, 16'h0006, 1'b0);
    exp_dq(3'h5, 16'h0006);
    pend(8'h05, 16'h0007, 1'b0);
    exp_dq(3'h4, 16'h0007);
    wb(1'b1, 8'h04, 32'h5, q);
    wb(1'b0, 8'h08, 32'h0, q);
    cmp("channel active", 32'h0, {31'h0, q[0]});
    pend(8'h05, 16'h000a, 1'b1);
    exp_dq(3'h0, 16'h000a);
    pend(8'h05, 16'h000b, 1'b0);
    urgent = 1'b1;
    pend(8'h05, 16'h000d, 1'b0);
    exp_dq(3'h0, 16'h000b);
    pend(8'h05, 16'h000e, 1'b0);
    urgent = 1'b0;
    exp_dq(3'h0, 16'h000d);
    exp_dq(3'h0, 16'h000f);
    exp_dq(3'h0, 16'h000e);
    exp_dq(3'h0, 16'h000c);
    cmp("link word", 32'h0015_000e, host.mem[55]);
    wb(1'b0, 8'h08, 32'h0, q);
    cmp("channel data", 32'h000e_0001, q);
    pend(8'h03, 16'h0008, 1'b0);
    exp_dq(3'h5, 16'h0008);
    uflow <= 1'b1;
    pend(8'h09, 16'h0009, 1'b0);
    exp_dq(3'h7, 16'h0009);
    uflow <= 1'b0;
    cfg(8'h09, 1'b0);
    pend(8'h09, 16'h0009, 1'b0);
    exp_dq(3'h0, 16'h0009);
    ma <= 1'b1;
    pend(8'h09, 16'h0009, 1'b0);
    exp_dq(3'h6, 16'h0009);
    ma <= 1'b0;
    wb(1'b0, 8'h08, 32'h0, q);
    cmp("channel active", 32'h0, {31'h0, q[0]});
    cfg(8'h09, 1'b0);
    xa <= 1'b1;
    pend(8'h09, 16'h0009, 1'b0);
    exp_dq(3'h6, 16'h0009);
    xa <= 1'b0;
    print_verdict();
  end
endmodule
